/* File: logic/ccss_top.sv */
// module: cpu clock source selection, oscillator stop interlocks and stop-release wait
//
// Summary of operation
// - internal clock selected: peripherals get divided internal clock
// - watchdog, monitor, timer stay enabled on internal
// - in subclock, only main-stop bit stops oscillator
// - status bits set shortest first, then stay set
// - counter stops at selected time; longer bits clear
// - wait counts only after oscillation has started
`timescale 1ns/10ps
module ccss_top
    import ccss_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    input wire logic hs_osc_running,
    input wire logic wake_event,
    output logic hs_osc_enable_q,
    output logic int_osc_enable_q,
    output logic cpu_use_internal_q,
    output logic cpu_use_subclock_q,
    output logic peri_from_internal_q,
    output logic [7:0] peri_clock_div_q,
    output logic general_peri_enable_q,
    output logic keep_on_peri_enable_q,
    output logic timer_h1_div_ok_q,
    output logic cpu_clock_gate_q
);
    // ------------------------------------------------------------
    // registers and synchronisers
    // ------------------------------------------------------------
    logic [7:0] main_clock_mode_reg_q;
    logic [7:0] main_osc_control_reg_q;
    logic [7:0] processor_clock_control_reg_q;
    logic [7:0] internal_osc_mode_reg_q;
    logic [2:0] stabilization_time_select_reg_q;
    logic [1:0] osc_sync_q;
    logic [1:0] wake_sync_q;
    logic osc_running;
    logic main_clock_status_flag;
    logic main_clock_source_select;
    logic cpu_subclock_select;
    logic stop_req;
    logic write_main_mode;
    logic write_proc_ctrl;
    ccss_stop_state_t state_q;
    ccss_stop_state_t state_d;
    logic [STAB_BITS-1:0] stab_status;
    logic stab_done;

    assign write_main_mode = reg_wr && reg_addr == ADDR_MAIN_CLOCK_MODE;
    assign write_proc_ctrl = reg_wr && reg_addr == ADDR_PROC_CLOCK_CONTROL;
    assign stop_req = reg_wr && reg_addr == ADDR_STOP_CONTROL && reg_wdata[STOPC_ENTER_BIT];
    assign main_clock_source_select = main_clock_mode_reg_q[MODE_SOURCE_SELECT_BIT];
    assign cpu_subclock_select = processor_clock_control_reg_q[PROC_SUBCLOCK_SELECT_BIT];
    // status flag: high-speed clock is actually the main source
    assign main_clock_status_flag = main_clock_source_select && osc_running;
    assign osc_running = osc_sync_q[1];

    // oscillator ready and wake come from outside: two flops first
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            osc_sync_q <= 2'h0;
            wake_sync_q <= 2'h0;
        end
        else
        begin
            osc_sync_q <= {osc_sync_q[0], hs_osc_running};
            wake_sync_q <= {wake_sync_q[0], wake_event};
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // main clock mode: source select writable, status bit is read-only
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            main_clock_mode_reg_q <= MODE_RESET;
        end
        else if (write_main_mode)
        begin
            main_clock_mode_reg_q <= {7'h00, reg_wdata[MODE_SOURCE_SELECT_BIT]};
        end
    end

    // high-speed oscillator stop bit; ignored while on subclock
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            main_osc_control_reg_q <= OSC_CTRL_RESET;
        end
        else if (reg_wr && reg_addr == ADDR_MAIN_OSC_CONTROL && !cpu_subclock_select)
        begin
            main_osc_control_reg_q <= {reg_wdata[OSC_HS_STOP_BIT], 7'h00};
        end
    end

    // processor clock control; reserved bit held at zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            processor_clock_control_reg_q <= PROC_CTRL_RESET;
        end
        else if (write_proc_ctrl)
        begin
            processor_clock_control_reg_q <= reg_wdata & ~(8'h01 << PROC_RESERVED_ZERO_BIT);
            // leaving subclock only takes when main clock really runs
            if (cpu_subclock_select && !reg_wdata[PROC_SUBCLOCK_SELECT_BIT]
                && !(main_clock_status_flag && main_clock_source_select))
            begin
                processor_clock_control_reg_q[PROC_SUBCLOCK_SELECT_BIT] <= 1'b1;
            end
        end
    end

    // internal oscillator mode and stabilization time select
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            internal_osc_mode_reg_q <= INT_OSC_MODE_RESET;
            stabilization_time_select_reg_q <= STAB_SEL_RESET;
        end
        else
        begin
            if (reg_wr && reg_addr == ADDR_INTERNAL_OSC_MODE)
            begin
                internal_osc_mode_reg_q <= {7'h00, reg_wdata[INT_OSC_STOP_BIT]};
            end
            if (reg_wr && reg_addr == ADDR_STAB_TIME_SELECT)
            begin
                // out-of-range selects clamp to the longest wait
                stabilization_time_select_reg_q <= (reg_wdata[2:0] > STAB_SEL_MAX)
                    ? STAB_SEL_MAX : reg_wdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // stop mode and release wait
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CCSS_RUN:
            begin
                if (stop_req)
                begin
                    state_d = CCSS_STOPPED;
                end
            end
            CCSS_STOPPED:
            begin
                if (wake_sync_q[1])
                begin
                    state_d = CCSS_STARTUP;
                end
            end
            // startup delay not counted: wait for the oscillator
            CCSS_STARTUP:
            begin
                if (osc_running)
                begin
                    state_d = CCSS_WAIT;
                end
            end
            CCSS_WAIT:
            begin
                if (stab_done)
                begin
                    state_d = CCSS_RUN;
                end
            end
            default:
            begin
                state_d = CCSS_RUN;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= CCSS_STARTUP; // reset release also waits for oscillation
        end
        else
        begin
            state_q <= state_d;
        end
    end

    ccss_stab_counter u_stab
    (
        .clk(clk),
        .rst(rst),
        .clear(stop_req && state_q == CCSS_RUN),
        .count_en(state_q == CCSS_WAIT),
        .select(stabilization_time_select_reg_q),
        .status_q(stab_status),
        .done_q(stab_done)
    );

    // ------------------------------------------------------------
    // clock routing outputs
    // ------------------------------------------------------------
    // oscillator enables: in subclock the main-stop bit stops high speed
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hs_osc_enable_q <= 1'b0;
            int_osc_enable_q <= 1'b1;
            cpu_clock_gate_q <= 1'b0;
        end
        else
        begin
            hs_osc_enable_q <= (state_q != CCSS_STOPPED) && (cpu_subclock_select
                ? !processor_clock_control_reg_q[PROC_MAIN_STOP_SUB_BIT]
                : !main_osc_control_reg_q[OSC_HS_STOP_BIT]);
            int_osc_enable_q <= (state_q != CCSS_STOPPED) && !internal_osc_mode_reg_q[INT_OSC_STOP_BIT];
            cpu_clock_gate_q <= (state_q == CCSS_RUN);
        end
    end

    // source selection and peripheral clock derivation
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cpu_use_internal_q <= 1'b1;
            cpu_use_subclock_q <= 1'b0;
            peri_from_internal_q <= 1'b1;
            peri_clock_div_q <= PERI_DIV_ONE;
            general_peri_enable_q <= 1'b0;
            keep_on_peri_enable_q <= 1'b1;
            timer_h1_div_ok_q <= 1'b1;
        end
        else
        begin
            cpu_use_subclock_q <= cpu_subclock_select;
            cpu_use_internal_q <= !cpu_subclock_select && !main_clock_status_flag;
            // divided internal oscillator output feeds peripherals
            peri_from_internal_q <= !cpu_subclock_select && !main_clock_status_flag;
            peri_clock_div_q <= PERI_DIV_ONE << processor_clock_control_reg_q[PROC_DIV_MSB:PROC_DIV_LSB];
            // general peripherals are not guaranteed on the internal clock
            general_peri_enable_q <= cpu_subclock_select || main_clock_status_flag;
            keep_on_peri_enable_q <= 1'b1;
            timer_h1_div_ok_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // register read, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata_q <= 8'h00;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_MAIN_CLOCK_MODE: reg_rdata_q <= {6'h00, main_clock_status_flag, main_clock_source_select};
                ADDR_MAIN_OSC_CONTROL: reg_rdata_q <= main_osc_control_reg_q;
                ADDR_STAB_STATUS: reg_rdata_q <= {3'h0, stab_status};
                ADDR_STAB_TIME_SELECT: reg_rdata_q <= {5'h00, stabilization_time_select_reg_q};
                ADDR_PROC_CLOCK_CONTROL: reg_rdata_q <= processor_clock_control_reg_q;
                ADDR_INTERNAL_OSC_MODE: reg_rdata_q <= internal_osc_mode_reg_q;
                ADDR_STOP_CONTROL: reg_rdata_q <= {7'h00, state_q == CCSS_RUN};
                default: reg_rdata_q <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata_q <= 8'h00;
        end
    end
endmodule // ccss_top

/* File: logic/ccss_pkg.sv */
// package: register map, field positions and timing constants of the cpu clock source switch
package ccss_pkg;
    // register indices on the plain register port
    localparam logic [2:0] ADDR_MAIN_CLOCK_MODE = 3'h0;
    localparam logic [2:0] ADDR_MAIN_OSC_CONTROL = 3'h1;
    localparam logic [2:0] ADDR_STAB_STATUS = 3'h2;
    localparam logic [2:0] ADDR_STAB_TIME_SELECT = 3'h3;
    localparam logic [2:0] ADDR_PROC_CLOCK_CONTROL = 3'h4;
    localparam logic [2:0] ADDR_INTERNAL_OSC_MODE = 3'h5;
    localparam logic [2:0] ADDR_STOP_CONTROL = 3'h6;

    // main clock mode register fields
    localparam int MODE_SOURCE_SELECT_BIT = 0;
    localparam int MODE_STATUS_BIT = 1;
    // main oscillator control register fields
    localparam int OSC_HS_STOP_BIT = 7;
    // processor clock control register fields
    localparam int PROC_SUBCLOCK_SELECT_BIT = 4;
    localparam int PROC_RESERVED_ZERO_BIT = 3;
    localparam int PROC_MAIN_STOP_SUB_BIT = 7;
    localparam int PROC_DIV_LSB = 0;
    localparam int PROC_DIV_MSB = 2;
    // internal oscillator mode register fields
    localparam int INT_OSC_STOP_BIT = 0;
    // stop control register fields (stop request)
    localparam int STOPC_ENTER_BIT = 0;

    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] OSC_CTRL_RESET = 8'h80;
    localparam logic [7:0] PROC_CTRL_RESET = 8'h00;
    localparam logic [7:0] INT_OSC_MODE_RESET = 8'h00;
    localparam logic [2:0] STAB_SEL_RESET = 3'h5;
    localparam logic [2:0] STAB_SEL_MAX = 3'h5;

    // stabilization status bits, shortest interval first
    localparam int STAB_BITS = 5;
    localparam int STAB_CNT_W = 18;
    // counter bit of the shortest interval: 2^13 cycles
    localparam int STAB_FIRST_LOG2 = 13;
    // internal oscillator nominal rate and the peripheral divide from it
    localparam int INT_OSC_KHZ = 240;
    localparam int PERI_TIMER_DIV_LOG2 = 7;
    localparam logic [7:0] PERI_DIV_ONE = 8'h01;

    typedef enum logic [3:0]
    {
        CCSS_RUN = 4'h1,
        CCSS_STOPPED = 4'h2,
        CCSS_STARTUP = 4'h4,
        CCSS_WAIT = 4'h8
    } ccss_stop_state_t;
endpackage

/* File: logic/ccss_stab_counter.sv */
// module: oscillation stabilization counter with sticky, ordered status bits
`timescale 1ns/10ps
module ccss_stab_counter
    import ccss_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic count_en,
    input wire logic [2:0] select,
    output logic [STAB_BITS-1:0] status_q,
    output logic done_q
);
    logic [STAB_CNT_W-1:0] count_q;
    logic [STAB_BITS-1:0] reached;

    // thresholds 2^(n+13) cycles; bit 0 is the shortest interval
    always_comb
    begin
        for (int i = 0; i < STAB_BITS; i++)
        begin
            reached[i] = count_q[STAB_FIRST_LOG2 + i] && (i < int'(select));
        end
    end

    // counter stops at the selected interval, longer bits never set
    always_ff @(posedge clk)
    begin
        if (rst || clear)
        begin
            count_q <= '0;
        end
        else if (count_en && !done_q)
        begin
            count_q <= count_q + 1'b1;
        end
    end

    // bits set in order and stay set until the next stop entry
    always_ff @(posedge clk)
    begin
        if (rst || clear)
        begin
            status_q <= '0;
        end
        else
        begin
            status_q <= status_q | reached;
        end
    end

    // done once the selected interval's bit is up
    always_ff @(posedge clk)
    begin
        if (rst || clear)
        begin
            done_q <= 1'b0;
        end
        else if (select == 3'h0 || reached[select - 3'h1])
        begin
            done_q <= count_en;
        end
    end
endmodule // ccss_stab_counter

/* File: dv/ccss_osc_model.sv */
// partner model: high-speed oscillator with a start-up delay
`timescale 1ns/10ps
module ccss_osc_model
#(
    parameter int START_CYC = 20
)
(
    input wire logic clk,
    input wire logic enable,
    output logic running
);
    // ------------------------------
    // oscillation start-up
    // ------------------------------
    int cnt = 0;
    initial running = 1'b0;

    // rises only after the start-up delay, drops at once when disabled
    always @(posedge clk)
    begin
        if (!enable)
        begin
            cnt <= 0;
            running <= 1'b0;
        end
        else if (cnt < START_CYC)
            cnt <= cnt + 1;
        else
            running <= 1'b1;
    end
endmodule // ccss_osc_model

/* File: dv/ccss_top_assertions.sv */
// checker: port-level properties of the cpu clock source switch
`timescale 1ns/10ps
module ccss_top_checker
    import ccss_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic hs_osc_running,
    input wire logic hs_osc_enable_q,
    input wire logic int_osc_enable_q,
    input wire logic cpu_use_internal_q,
    input wire logic cpu_use_subclock_q,
    input wire logic peri_from_internal_q,
    input wire logic [7:0] peri_clock_div_q,
    input wire logic general_peri_enable_q,
    input wire logic keep_on_peri_enable_q,
    input wire logic timer_h1_div_ok_q,
    input wire logic cpu_clock_gate_q
);
    // ------------------------------
    // helper state
    // ------------------------------
    logic rd_stat_q;
    logic [4:0] last_q;
    logic [15:0] run_cnt_q;
    wire [4:0] stat = reg_rdata_q[4:0];

    // last status seen while running; cycles of steady oscillation
    always_ff @(posedge clk)
    begin
        rd_stat_q <= reg_rd && reg_addr == ADDR_STAB_STATUS && !rst;
        if (rst || !cpu_clock_gate_q)
            last_q <= 5'h00;
        else if (rd_stat_q)
            last_q <= stat;
        if (rst || !hs_osc_running)
            run_cnt_q <= 16'h0000;
        else if (run_cnt_q != 16'hffff)
            run_cnt_q <= run_cnt_q + 16'h0001;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence osc_ctl_wr_sub_s;
        (reg_wr && reg_addr == ADDR_MAIN_OSC_CONTROL && cpu_use_subclock_q) ##1 !reg_wr;
    endsequence
    sequence stop_req_s;
        cpu_clock_gate_q && reg_wr && reg_addr == ADDR_STOP_CONTROL && reg_wdata[0];
    endsequence

    // ------------------------------
    // properties
    // ------------------------------
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
        else $error("read data not zero outside a read");
    keep_on_a: assert property (!$past(rst) |-> keep_on_peri_enable_q && timer_h1_div_ok_q)
        else $error("always-usable peripherals disabled");
    internal_peri_a: assert property ($stable(cpu_use_internal_q) && cpu_use_internal_q
        |-> peri_from_internal_q && !general_peri_enable_q) else $error("internal clock peripheral feed wrong");
    peri_div_a: assert property ($onehot(peri_clock_div_q))
        else $error("peripheral divide not a power of two");
    osc_stop_ignored_a: assert property (osc_ctl_wr_sub_s |-> $stable(hs_osc_enable_q) [*2])
        else $error("oscillator stop honoured on subclock");
    sub_exit_a: assert property ((cpu_use_subclock_q && !hs_osc_running) [*5] |=> cpu_use_subclock_q)
        else $error("subclock left without oscillation");
    gate_after_osc_a: assert property ($rose(cpu_clock_gate_q) |-> run_cnt_q >= 16'h0002)
        else $error("clock released before oscillation");
    stat_order_a: assert property (rd_stat_q |-> (stat & (stat + 5'h01)) == 5'h00)
        else $error("status bits set out of order");
    stat_sticky_a: assert property (rd_stat_q && cpu_clock_gate_q |-> (stat & last_q) == last_q)
        else $error("status bit dropped while running");
    stop_entry_a: assert property (stop_req_s |-> ##[1:2] !cpu_clock_gate_q && !hs_osc_enable_q)
        else $error("stop entry did not halt the clocks");
endmodule // ccss_top_checker

/* File: dv/ccss_top_bench.sv */
// testbench: reset values, start-up wait, stop and wake, clock source switches
`timescale 1ns/10ps
module ccss_top_bench
    import ccss_pkg::*;
();
    // ------------------------------
    // signals and instances
    // ------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic wake_event = 1'b0;
    logic hs_osc_running, hs_osc_enable_q, int_osc_enable_q, cpu_use_internal_q, cpu_use_subclock_q;
    logic peri_from_internal_q, general_peri_enable_q, keep_on_peri_enable_q, timer_h1_div_ok_q;
    logic cpu_clock_gate_q;
    logic [7:0] reg_rdata_q, peri_clock_div_q;
    int err_total = 0;
    int checked = 0;
    int n;

    ccss_top dut_u (.*);
    ccss_osc_model #(.START_CYC(20)) osc_u (.clk(clk), .enable(hs_osc_enable_q), .running(hs_osc_running));

    always #20 clk = ~clk;

    // tasks start and end just after a rising edge
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // extra edge so registered outputs have landed on return
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        // read data stand only until the next edge: look mid-cycle
        @(negedge clk);
        check(what, reg_rdata_q, e);
        @(posedge clk);
    endtask

    task automatic wait_gate();
        n = 0;
        while (cpu_clock_gate_q !== 1'b1 && n < 40000)
        begin
            @(posedge clk);
            n++;
        end
        check("clock gate", cpu_clock_gate_q, 8'h01);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset();
        check("peri internal", peri_from_internal_q, 8'h01);
        check("cpu internal", cpu_use_internal_q, 8'h01);
        check("general off", general_peri_enable_q, 8'h00);
        check("keep on", keep_on_peri_enable_q & timer_h1_div_ok_q, 8'h01);
        rchk("mode reset", ADDR_MAIN_CLOCK_MODE, MODE_RESET);
        rchk("osc control reset", ADDR_MAIN_OSC_CONTROL, OSC_CTRL_RESET);
        rchk("proc control reset", ADDR_PROC_CLOCK_CONTROL, PROC_CTRL_RESET);
        rchk("int osc mode reset", ADDR_INTERNAL_OSC_MODE, INT_OSC_MODE_RESET);
        rchk("stab select reset", ADDR_STAB_TIME_SELECT, {5'h00, STAB_SEL_RESET});
        rchk("unmapped", 3'h7, 8'h00);
        wr(ADDR_STAB_TIME_SELECT, 8'h07);
        rchk("stab select clamp", ADDR_STAB_TIME_SELECT, {5'h00, STAB_SEL_MAX});
        $display("reset test done");
    endtask

    // no oscillation means no release; then 2^13 counted cycles
    task automatic t_startup();
        wr(ADDR_STAB_TIME_SELECT, 8'h01);
        repeat (100) @(posedge clk);
        check("held without osc", cpu_clock_gate_q, 8'h00);
        wr(ADDR_MAIN_OSC_CONTROL, 8'h00);
        wait_gate();
        check("wait 2^13", n >= 8192, 8'h01);
        rchk("one status bit", ADDR_STAB_STATUS, 8'h01);
        $display("startup test done");
    endtask

    task automatic t_stop();
        wr(ADDR_STAB_TIME_SELECT, 8'h02);
        wr(ADDR_STOP_CONTROL, 8'h01);
        check("gate off", cpu_clock_gate_q, 8'h00);
        rchk("status cleared", ADDR_STAB_STATUS, 8'h00);
        wake_event <= 1'b1;
        repeat (4) @(posedge clk);
        wake_event <= 1'b0;
        wait_gate();
        check("wait 2^14", n >= 16384, 8'h01);
        rchk("two status bits", ADDR_STAB_STATUS, 8'h03);
        $display("stop test done");
    endtask

    task automatic t_switch();
        for (int k = 0; k < 8; k++)
        begin
            wr(ADDR_PROC_CLOCK_CONTROL, 8'(k));
            check("peri div", peri_clock_div_q, 8'h01 << k);
        end
        wr(ADDR_PROC_CLOCK_CONTROL, 8'h00);
        wr(ADDR_MAIN_CLOCK_MODE, 8'h01);
        rchk("main status", ADDR_MAIN_CLOCK_MODE, 8'h03);
        wr(ADDR_INTERNAL_OSC_MODE, 8'h01);
        check("int osc off", int_osc_enable_q, 8'h00);
        check("general on", general_peri_enable_q, 8'h01);
        check("cpu not internal", cpu_use_internal_q, 8'h00);
        check("peri not internal", peri_from_internal_q, 8'h00);
        wr(ADDR_PROC_CLOCK_CONTROL, 8'h10);
        check("sub on", cpu_use_subclock_q, 8'h01);
        wr(ADDR_MAIN_OSC_CONTROL, 8'h80);
        check("stop bit ignored", hs_osc_enable_q, 8'h01);
        rchk("osc control kept", ADDR_MAIN_OSC_CONTROL, 8'h00);
        wr(ADDR_PROC_CLOCK_CONTROL, 8'h90);
        check("main stop", hs_osc_enable_q, 8'h00);
        repeat (8) @(posedge clk);
        wr(ADDR_PROC_CLOCK_CONTROL, 8'h80);
        check("exit refused", cpu_use_subclock_q, 8'h01);
        wr(ADDR_PROC_CLOCK_CONTROL, 8'h10);
        repeat (40) @(posedge clk);
        rchk("exit ready", ADDR_MAIN_CLOCK_MODE, 8'h03);
        wr(ADDR_PROC_CLOCK_CONTROL, 8'h00);
        check("exit taken", cpu_use_subclock_q, 8'h00);
        wr(ADDR_INTERNAL_OSC_MODE, 8'h00);
        // general peripherals are still enabled here; nothing blocks the switch to internal
        wr(ADDR_MAIN_CLOCK_MODE, 8'h00);
        rchk("back internal", ADDR_MAIN_CLOCK_MODE, 8'h00);
        check("general off again", general_peri_enable_q, 8'h00);
        check("cpu internal again", cpu_use_internal_q, 8'h01);
        wr(ADDR_MAIN_OSC_CONTROL, 8'h80);
        check("hs stopped", hs_osc_enable_q, 8'h00);
        $display("switch test done");
    endtask

    // ------------------------------
    // sequence and watchdog
    // ------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_startup();
        t_stop();
        t_switch();
        tally_and_finish();
    end

    // the tests need some 25000 cycles
    initial
    begin
        repeat (90000) @(posedge clk);
        err_total++;
        $display("[FAIL] watchdog expected done seen timeout");
        tally_and_finish();
    end
endmodule // ccss_top_bench

bind ccss_top ccss_top_checker chk_u (.*);
